/* File: src/pfr_pkg.sv */
// Package for the port function routing block: register map, field layout, reset values.
// Assumes a 32-bit AXI4-Lite register bus and a small bank of general port pins.
package pfr_pkg;

  localparam int PFR_NPINS = 8;
  localparam int PFR_AW = 8;

  // Register byte offsets
  localparam logic [PFR_AW-1:0] PFR_OFF_LATCH = 8'h00;
  localparam logic [PFR_AW-1:0] PFR_OFF_DIR = 8'h04;
  localparam logic [PFR_AW-1:0] PFR_OFF_PULLUP = 8'h08;
  localparam logic [PFR_AW-1:0] PFR_OFF_BUFSEL = 8'h0C;
  localparam logic [PFR_AW-1:0] PFR_OFF_DRIVE = 8'h10;
  localparam logic [PFR_AW-1:0] PFR_OFF_THRESH = 8'h14;
  localparam logic [PFR_AW-1:0] PFR_OFF_SLEW = 8'h18;
  localparam logic [PFR_AW-1:0] PFR_OFF_SNZCTL = 8'h1C;
  localparam logic [PFR_AW-1:0] PFR_OFF_REDIR = 8'h20;
  localparam logic [PFR_AW-1:0] PFR_OFF_RDSEL = 8'h24;
  localparam logic [PFR_AW-1:0] PFR_OFF_ANALOG = 8'h28;
  localparam logic [PFR_AW-1:0] PFR_OFF_PIN = 8'h2C;

  // Pin positions within the bank
  localparam int PFR_PIN_LRX = 0;
  localparam int PFR_PIN_RTC = 1;
  localparam int PFR_PIN_SNZ = 2;
  localparam int PFR_PIN_LTX = 3;

  // Redirect register and read source register bit positions
  localparam int PFR_BIT_LRX = 0;
  localparam int PFR_BIT_RTC = 1;
  localparam int PFR_BIT_SNZ = 2;
  localparam int PFR_BIT_LTX = 3;
  localparam int PFR_BIT_RDSRC = 0;

  // Snooze enable bit and output instance selector field in the snooze control register
  localparam int PFR_SNZ_EN = 0;
  localparam int PFR_SNZ_SEL_LSB = 4;
  localparam int PFR_SNZ_SEL_W = 3;

  // Reset values: all pins input, latches low
  localparam logic [31:0] PFR_RST_DIR = 32'h000000FF;
  localparam logic [31:0] PFR_RST_ZERO = 32'h00000000;

  localparam logic [1:0] PFR_RESP_OKAY = 2'h0;
  localparam logic [1:0] PFR_RESP_SLVERR = 2'h2;

  // Per-pin attributes towards the pad
  typedef struct packed {
    logic [PFR_NPINS-1:0] pullup_enable;
    logic [PFR_NPINS-1:0] input_buffer_sel;
    logic [PFR_NPINS-1:0] input_threshold_sel;
    logic [PFR_NPINS-1:0] slew_rate_sel;
    logic [PFR_NPINS-1:0] analog_digital_select;
  } pfr_pad_cfg_s;

endpackage : pfr_pkg

/* File: src/pfr_top.sv */
// Port function routing: per-pin direction, latch, attributes and peripheral redirection.
// Assumes pad inputs synchronous to aclk and an AXI4-Lite master with one access of each kind at a time.
//
// Functional notes
// - Redirect bit 0 routes LIN receive zero from pin 14
// - Input pin latch read returns live pin level
// - Direction 1 means input, driver off
// - Buffer select 0 means normal input buffer
// - Per-pin pull-up enable for input pins
// - Threshold select picks one of two Schmitt variants
// - Direction 0 enables the output driver
// - Drive mode 0 gives push-pull output
// - Read source 1 returns output pin level
// - Redirect bit 0 drives second pulse on pin 15
// - Redirect bit 0 drives snooze zero on pin 30
// - Slew select 0 gives normal slew rate
// - Snooze enable gates snooze status onto pin
// - Eight snooze status instances, zero to seven
// - Two LIN instances with own pin routing; here only instance zero is routed, the other receive is held high
// - Drive mode 1 gives open-drain, low only
// - Buffer select picks normal or TTL buffer
// - Unrouted pin stays general I/O, one function
`timescale 1ns/1ps
module pfr_top import pfr_pkg::*; #(
  parameter int NPINS = PFR_NPINS,
  parameter int NLIN = 2,
  parameter int NSNZ = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [PFR_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [PFR_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [NPINS-1:0] pin_in,
  output logic [NPINS-1:0] pin_out,
  output logic [NPINS-1:0] pin_oe_n,
  output pfr_pad_cfg_s pad_cfg,
  output logic [NLIN-1:0] lin_rx_in,
  input wire logic [NLIN-1:0] lin_tx_out,
  input wire logic rtc_second_pulse_out,
  input wire logic [NSNZ-1:0] snooze_status_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [NPINS-1:0] latch_reg;
  logic [NPINS-1:0] port_direction_reg;
  logic [NPINS-1:0] pullup_enable_reg;
  logic [NPINS-1:0] input_buffer_sel_reg;
  logic [NPINS-1:0] output_drive_mode_reg;
  logic [NPINS-1:0] input_threshold_sel_reg;
  logic [NPINS-1:0] slew_rate_sel_reg;
  logic [NPINS-1:0] analog_digital_select_reg;
  logic [31:0] snooze_output_ctrl_reg;
  logic [31:0] peripheral_redirect_sel_reg;
  logic port_read_source_reg;
  logic [NPINS-1:0] pin_level_reg;

  // Routed functions per pin
  logic [NPINS-1:0] periph_out_en;
  logic [NPINS-1:0] periph_out_val;
  logic [NPINS-1:0] drive_next;
  logic [NPINS-1:0] oe_n_next;
  logic snooze_out_enable;
  logic [PFR_SNZ_SEL_W-1:0] snz_sel;
  logic snz_sig;

  assign snooze_out_enable = snooze_output_ctrl_reg[PFR_SNZ_EN];
  assign snz_sel = snooze_output_ctrl_reg[PFR_SNZ_SEL_LSB +: PFR_SNZ_SEL_W];
  // Instance chosen by index; the upper instances share the same pin here
  assign snz_sig = snooze_status_out[snz_sel] & snooze_out_enable;

  always_comb begin
    periph_out_en = '0;
    periph_out_val = '0;
    // Redirect bit clear selects the default pin for each function
    if (!peripheral_redirect_sel_reg[PFR_BIT_RTC]) begin
      periph_out_en[PFR_PIN_RTC] = 1'b1;
      periph_out_val[PFR_PIN_RTC] = rtc_second_pulse_out;
    end
    if (!peripheral_redirect_sel_reg[PFR_BIT_SNZ]) begin
      periph_out_en[PFR_PIN_SNZ] = 1'b1;
      periph_out_val[PFR_PIN_SNZ] = snz_sig;
    end
    if (!peripheral_redirect_sel_reg[PFR_BIT_LTX]) begin
      periph_out_en[PFR_PIN_LTX] = 1'b1;
      periph_out_val[PFR_PIN_LTX] = lin_tx_out[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pad drive: one generate entry per pin
  genvar gi;
  generate
    for (gi = 0; gi < NPINS; gi++) begin : g_pin
      logic val;
      // Latch 0 lets the peripheral through; a 1 forces the output value high
      // Unrouted pins stay plain I/O from the latch
      assign val = periph_out_en[gi] ? (periph_out_val[gi] | latch_reg[gi]) : latch_reg[gi];
      // Analog pins never drive; open-drain releases for a high
      assign oe_n_next[gi] = port_direction_reg[gi] | analog_digital_select_reg[gi] |
                             (output_drive_mode_reg[gi] & val);
      assign drive_next[gi] = output_drive_mode_reg[gi] ? 1'b0 : val;
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_out <= '0;
      pin_oe_n <= '1;
    end else begin
      pin_out <= drive_next;
      pin_oe_n <= oe_n_next;
    end
  end

  // Pad attributes come from their registers; pull-up enable is masked to input pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pad_cfg <= '0;
    end else begin
      pad_cfg.pullup_enable <= pullup_enable_reg & port_direction_reg;
      pad_cfg.input_buffer_sel <= input_buffer_sel_reg;
      pad_cfg.input_threshold_sel <= input_threshold_sel_reg;
      pad_cfg.slew_rate_sel <= slew_rate_sel_reg;
      pad_cfg.analog_digital_select <= analog_digital_select_reg;
    end
  end

  // LIN receive: instance zero from its default pin, idle high when redirected away
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lin_rx_in <= '1;
    end else begin
      lin_rx_in <= '1;
      if (!peripheral_redirect_sel_reg[PFR_BIT_LRX]) begin
        lin_rx_in[0] <= pin_in[PFR_PIN_LRX];
      end
    end
  end

  // Pin level sampled each cycle for reads
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_level_reg <= '0;
    end else begin
      pin_level_reg <= pin_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write: address and data taken in either order, response after both
  logic aw_held;
  logic w_held;
  logic [PFR_AW-1:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic [31:0] wmask;

  assign wr_fire = aw_held && w_held && !s_axi_bvalid;
  assign wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  function automatic logic wr_known(input logic [PFR_AW-1:0] a);
    wr_known = (a == PFR_OFF_LATCH) || (a == PFR_OFF_DIR) || (a == PFR_OFF_PULLUP) ||
               (a == PFR_OFF_BUFSEL) || (a == PFR_OFF_DRIVE) || (a == PFR_OFF_THRESH) ||
               (a == PFR_OFF_SLEW) || (a == PFR_OFF_SNZCTL) || (a == PFR_OFF_REDIR) ||
               (a == PFR_OFF_RDSEL) || (a == PFR_OFF_ANALOG);
  endfunction : wr_known

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [31:0] m);
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // Strobes act on the addressed register's present value, so a partial write keeps the other bytes
  logic [31:0] wr_old;
  logic [31:0] wr_word;

  always_comb begin
    wr_old = '0;
    unique case (aw_addr_reg)
      PFR_OFF_LATCH: wr_old = 32'(latch_reg);
      PFR_OFF_DIR: wr_old = 32'(port_direction_reg);
      PFR_OFF_PULLUP: wr_old = 32'(pullup_enable_reg);
      PFR_OFF_BUFSEL: wr_old = 32'(input_buffer_sel_reg);
      PFR_OFF_DRIVE: wr_old = 32'(output_drive_mode_reg);
      PFR_OFF_THRESH: wr_old = 32'(input_threshold_sel_reg);
      PFR_OFF_SLEW: wr_old = 32'(slew_rate_sel_reg);
      PFR_OFF_ANALOG: wr_old = 32'(analog_digital_select_reg);
      PFR_OFF_SNZCTL: wr_old = snooze_output_ctrl_reg;
      PFR_OFF_REDIR: wr_old = peripheral_redirect_sel_reg;
      PFR_OFF_RDSEL: wr_old[PFR_BIT_RDSRC] = port_read_source_reg;
      default: wr_old = '0;
    endcase
  end

  assign wr_word = merge(wr_old, w_data_reg, wmask);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= PFR_RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_known(aw_addr_reg) ? PFR_RESP_OKAY : PFR_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes; pin attributes are plain storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_reg <= PFR_RST_ZERO[NPINS-1:0];
      port_direction_reg <= PFR_RST_DIR[NPINS-1:0];
      pullup_enable_reg <= PFR_RST_ZERO[NPINS-1:0];
      input_buffer_sel_reg <= PFR_RST_ZERO[NPINS-1:0];
      output_drive_mode_reg <= PFR_RST_ZERO[NPINS-1:0];
      input_threshold_sel_reg <= PFR_RST_ZERO[NPINS-1:0];
      slew_rate_sel_reg <= PFR_RST_ZERO[NPINS-1:0];
      analog_digital_select_reg <= PFR_RST_ZERO[NPINS-1:0];
      snooze_output_ctrl_reg <= PFR_RST_ZERO;
      peripheral_redirect_sel_reg <= PFR_RST_ZERO;
      port_read_source_reg <= 1'b0;
    end else if (wr_fire) begin
      unique case (aw_addr_reg)
        PFR_OFF_LATCH: latch_reg <= wr_word[NPINS-1:0];
        PFR_OFF_DIR: port_direction_reg <= wr_word[NPINS-1:0];
        PFR_OFF_PULLUP: pullup_enable_reg <= wr_word[NPINS-1:0];
        PFR_OFF_BUFSEL: input_buffer_sel_reg <= wr_word[NPINS-1:0];
        PFR_OFF_DRIVE: output_drive_mode_reg <= wr_word[NPINS-1:0];
        PFR_OFF_THRESH: input_threshold_sel_reg <= wr_word[NPINS-1:0];
        PFR_OFF_SLEW: slew_rate_sel_reg <= wr_word[NPINS-1:0];
        PFR_OFF_ANALOG: analog_digital_select_reg <= wr_word[NPINS-1:0];
        PFR_OFF_SNZCTL: snooze_output_ctrl_reg <= wr_word;
        // Peripheral must already be stopped; no interlock here
        PFR_OFF_REDIR: peripheral_redirect_sel_reg <= wr_word;
        PFR_OFF_RDSEL: port_read_source_reg <= wr_word[PFR_BIT_RDSRC];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read: one cycle from address acceptance to data
  logic [31:0] rd_next;
  logic rd_ok;

  always_comb begin
    rd_next = '0;
    rd_ok = 1'b1;
    unique case (s_axi_araddr)
      // Input pins show the pin; output pins show pin or latch by read source
      PFR_OFF_LATCH: rd_next = 32'((pin_level_reg & port_direction_reg) |
                               ((port_read_source_reg ? pin_level_reg : latch_reg) & ~port_direction_reg));
      PFR_OFF_DIR: rd_next = 32'(port_direction_reg);
      PFR_OFF_PULLUP: rd_next = 32'(pullup_enable_reg);
      PFR_OFF_BUFSEL: rd_next = 32'(input_buffer_sel_reg);
      PFR_OFF_DRIVE: rd_next = 32'(output_drive_mode_reg);
      PFR_OFF_THRESH: rd_next = 32'(input_threshold_sel_reg);
      PFR_OFF_SLEW: rd_next = 32'(slew_rate_sel_reg);
      PFR_OFF_ANALOG: rd_next = 32'(analog_digital_select_reg);
      PFR_OFF_SNZCTL: rd_next = snooze_output_ctrl_reg;
      PFR_OFF_REDIR: rd_next = peripheral_redirect_sel_reg;
      PFR_OFF_RDSEL: rd_next = 32'(port_read_source_reg);
      PFR_OFF_PIN: rd_next = 32'(pin_level_reg);
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= PFR_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_next;
      s_axi_rresp <= rd_ok ? PFR_RESP_OKAY : PFR_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule : pfr_top

/* File: dv/pfr_monitor.sv */
// Checker for the port function routing block: bus timing and pin relations.
// Assumes it is bound into pfr_top and sees only its ports.
`timescale 1ns/1ps
module pfr_monitor import pfr_pkg::*; #(
  parameter int NPINS = PFR_NPINS,
  parameter int NLIN = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [NPINS-1:0] pin_in,
  input wire logic [NPINS-1:0] pin_oe_n,
  input wire logic [NLIN-1:0] lin_rx_in
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////
  // Reset is synchronous, so the pins go quiet one edge after it is seen
  property p_reset_pins;
    disable iff (1'b0) !aresetn |=> (&pin_oe_n) && (&lin_rx_in);
  endproperty
  a_reset_pins: assert property (p_reset_pins) else $error("pins not idle after reset");
  property p_lin_spare;
    &lin_rx_in[NLIN-1:1];
  endproperty
  a_lin_spare: assert property (p_lin_spare) else $error("spare receive not idle");
  property p_lin_src;
    !lin_rx_in[0] |-> !$past(pin_in[PFR_PIN_LRX]);
  endproperty
  a_lin_src: assert property (p_lin_src) else $error("receive low without pin low");
  property p_b_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat) else $error("write response late");
  property p_r_lat;
    s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid;
  endproperty
  a_r_lat: assert property (p_r_lat) else $error("read response late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_w_quiet;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_w_quiet: assert property (p_w_quiet) else $error("write ready while response pending");
  property p_r_quiet;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_r_quiet: assert property (p_r_quiet) else $error("read ready while response pending");
  c_write: cover property (s_axi_bvalid && s_axi_bresp == PFR_RESP_OKAY);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == PFR_RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule : pfr_monitor

/* File: dv/pfr_periph_model.sv */
// Peripheral model: LIN transmit, second pulse and snooze status sources.
// Assumes the bench supplies the levels; outputs change only on aclk.
`timescale 1ns/1ps
module pfr_periph_model import pfr_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [10:0] pattern,
  output logic [1:0] lin_tx_out,
  output logic rtc_second_pulse_out,
  output logic [7:0] snooze_status_out
);
  // Idle LIN line is high, so reset parks it there
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lin_tx_out <= 2'h3;
      rtc_second_pulse_out <= 1'b0;
      snooze_status_out <= 8'h00;
    end else begin
      lin_tx_out <= pattern[10:9];
      rtc_second_pulse_out <= pattern[8];
      snooze_status_out <= pattern[7:0];
    end
  end
endmodule : pfr_periph_model

/* File: dv/pfr_bench.sv */
// Testbench for the port function routing block over AXI4-Lite.
// Assumes a pad that follows pin_oe_n and the peripheral model on the far side.
`timescale 1ns/1ps
module pfr_bench import pfr_pkg::*;;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid, rtc;
  logic [7:0] awaddr, araddr, ext, pin_in, pin_out, pin_oe_n, snz, oe;
  logic [31:0] wdata, rdata, rd, seed;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rs, lin_rx_in, lin_tx;
  logic [10:0] pat;
  logic [7:0] v [9];
  pfr_pad_cfg_s pad_cfg;
  int miscompares, checks_done;
  // Latch, drive and analog go before direction so a pin never drives a stale value
  localparam logic [7:0] OFFS [9] = '{PFR_OFF_LATCH, PFR_OFF_DRIVE, PFR_OFF_PULLUP, PFR_OFF_BUFSEL,
    PFR_OFF_THRESH, PFR_OFF_SLEW, PFR_OFF_RDSEL, PFR_OFF_ANALOG, PFR_OFF_DIR};
  assign pin_in = (~pin_oe_n & pin_out) | (pin_oe_n & ext);
  pfr_top pfr_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pad_cfg(pad_cfg), .lin_rx_in(lin_rx_in), .lin_tx_out(lin_tx),
    .rtc_second_pulse_out(rtc), .snooze_status_out(snz));
  pfr_periph_model pfr_periph_model_inst (.aclk(aclk), .aresetn(aresetn), .pattern(pat),
    .lin_tx_out(lin_tx), .rtc_second_pulse_out(rtc), .snooze_status_out(snz));
  ////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  function automatic logic [7:0] exp_rd(input logic [7:0] o, lat, dir, e, input logic src);
    logic [7:0] lev;
    lev = (~o & lat) | (o & e);
    return src ? lev : ((dir & lev) | (~dir & lat));
  endfunction : exp_rd
  task automatic chk(input string n, input logic [39:0] e, input logic [39:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while ((awvalid && !awready) || (wvalid && !wready));
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    rs = bresp;
  endtask : wr_reg
  // Ready is already high while idle, so the address is taken at the edge where valid is first seen
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    while (rvalid !== 1'b1) @(posedge aclk);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask : rd_reg
  task automatic print_verdict();
    if (miscompares == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : print_verdict
  ////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (20000) @(posedge aclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, ext, wdata, pat} = '0;
    wstrb = 4'hF;
    seed = 32'h0000000D;
    miscompares = 0;
    checks_done = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(PFR_OFF_DIR);
    chk("dir_reset", PFR_RST_DIR, rd);
    wr_reg(8'h30, 32'h1);
    chk("unmapped_wr", PFR_RESP_SLVERR, rs);
    rd_reg(8'h30);
    chk("unmapped_rd", PFR_RESP_SLVERR, rs);
    wr_reg(PFR_OFF_PIN, 32'h1);
    chk("ro_wr", PFR_RESP_SLVERR, rs);
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 9; k++) begin
        seed = lfsr_next(seed);
        v[k] = seed[7:0];
      end
      v[6] = v[6] & 8'h01;
      v[7] = v[7] & 8'hF0;
      v[8] = v[8] | 8'h0F;
      ext <= seed[15:8];
      for (int k = 0; k < 9; k++) wr_reg(OFFS[k], {24'h0, v[k]});
      repeat (3) @(posedge aclk);
      oe = v[8] | v[7] | (v[1] & v[0]);
      chk("pin_oe_n", oe, pin_oe_n);
      chk("pin_out", v[0] & ~oe, pin_out & ~pin_oe_n);
      chk("pad_cfg", {v[2] & v[8], v[3], v[4], v[5], v[7]}, pad_cfg);
      rd_reg(PFR_OFF_LATCH);
      chk("latch_rd", exp_rd(oe, v[0], v[8], ext, v[6][0]) & ~v[7], rd[7:0] & ~v[7]);
    end
    wr_reg(PFR_OFF_ANALOG, 32'h0);
    wr_reg(PFR_OFF_DRIVE, 32'h0);
    wr_reg(PFR_OFF_REDIR, 32'h0);
    wr_reg(PFR_OFF_LATCH, 32'h0);
    wr_reg(PFR_OFF_DIR, 32'hF1);
    for (int s = 0; s < 8; s++) begin
      seed = lfsr_next(seed);
      pat <= seed[10:0];
      ext <= seed[23:16];
      wr_reg(PFR_OFF_SNZCTL, 32'(s * 16 + 1));
      repeat (3) @(posedge aclk);
      chk("routed", {pat[9], pat[s], pat[8], ext[0]}, {pin_out[3:1], lin_rx_in[0]});
    end
    pat <= 11'h7FF;
    ext <= 8'h00;
    wr_reg(PFR_OFF_SNZCTL, 32'h0);
    repeat (3) @(posedge aclk);
    chk("snooze_off", 3'b101, pin_out[3:1]);
    wr_reg(PFR_OFF_LATCH, 32'h4);
    wr_reg(PFR_OFF_REDIR, 32'hF);
    repeat (3) @(posedge aclk);
    chk("unrouted", 4'b0101, {pin_out[3:1], lin_rx_in[0]});
    print_verdict();
  end
endmodule : pfr_bench
////////////////////////////////
bind pfr_top pfr_monitor #(.NPINS(NPINS), .NLIN(NLIN)) pfr_monitor_inst (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata), .pin_in(pin_in), .pin_oe_n(pin_oe_n),
  .lin_rx_in(lin_rx_in));
